// ### hdl/hrng_pkg.sv
package hrng_pkg;

	localparam int WORD_W = 32;
	localparam int BYTE_W = 8;

	// Health test: repetition count and window proportion
	localparam logic [5:0] RCT_LIMIT = 6'h28;
	localparam logic [5:0] RCT_RESET = 6'h01;
	localparam logic [8:0] APT_LAST = 9'h1ff;
	localparam logic [9:0] APT_LO = 10'h0c8;
	localparam logic [9:0] APT_HI = 10'h138;
	localparam logic [9:0] APT_MID = 10'h100;
	localparam logic [1:0] STARTUP_WINDOWS = 2'h2;

	// Entropy estimator: raw bits folded per internal bit
	localparam logic [9:0] EST_TIGHT = 10'h010;
	localparam logic [2:0] RATIO_LO = 3'h2;
	localparam logic [2:0] RATIO_HI = 3'h4;

	// Raw bits a finished byte waits before use
	localparam logic [5:0] QUAR_BITS = 6'h28;

	// Seeding length in bytes, output rate credit in bits
	localparam logic [4:0] SEED_BYTES = 5'h10;
	localparam logic [7:0] CREDIT_PER_BYTE = 8'h08;
	localparam logic [7:0] CREDIT_PER_WORD = 8'h20;
	localparam logic [7:0] CREDIT_MAX = 8'h80;

	// Deterministic generator
	localparam logic [3:0] DRG_ROUNDS = 4'h8;
	localparam logic [127:0] DRG_IV = 128'h6a09e667_bb67ae85_3c6ef372_a54ff53a;
	localparam logic [31:0] DRG_GEN_TWEAK = 32'h9e3779b9;

	typedef enum logic [3:0]
	{
		ST_START = 4'h1,
		ST_SEED = 4'h2,
		ST_RUN = 4'h4,
		ST_FAIL = 4'h8
	} hrng_state_t;

endpackage

// ### hdl/hrng_drg_if.sv
`timescale 1ns/100ps
interface hrng_drg_if;
	logic absorb_valid;
	logic [hrng_pkg::BYTE_W-1:0] absorb_byte;
	logic gen_req;
	logic busy;
	logic [hrng_pkg::WORD_W-1:0] gen_word;
	logic gen_done;

	modport core
	(
		input absorb_valid,
		input absorb_byte,
		input gen_req,
		output busy,
		output gen_word,
		output gen_done
	);

	modport ctrl
	(
		output absorb_valid,
		output absorb_byte,
		output gen_req,
		input busy,
		input gen_word,
		input gen_done
	);
endinterface // hrng_drg_if

// ### hdl/hrng_drg.sv
`timescale 1ns/100ps
module hrng_drg
(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Control side
	hrng_drg_if.core ifc
);

	logic [127:0] st_r, st_nxt, st_rnd;
	logic [3:0] cnt_r, cnt_nxt;
	logic mode_r, mode_nxt;
	logic [31:0] word_r, word_nxt;
	logic done_r, done_nxt;
	logic [31:0] a, b, c, d;

	function automatic logic [31:0] rotl(input logic [31:0] v, input int n);
		rotl = (v << n) | (v >> (32 - n));
	endfunction

	// One add-rotate-xor round over the four state words
	always_comb
	begin
		a = st_r[31:0];
		b = st_r[63:32];
		c = st_r[95:64];
		d = st_r[127:96];
		a = a + b;
		d = rotl(d ^ a, 16);
		c = c + d;
		b = rotl(b ^ c, 12);
		a = a + b;
		d = rotl(d ^ a, 8);
		c = c + d;
		b = rotl(b ^ c, 7);
		st_rnd = {c, b, a, d};
	end

	always_comb
	begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		mode_nxt = mode_r;
		word_nxt = word_r;
		done_nxt = 1'b0;
		if (cnt_r == 4'h0)
		begin
			if (ifc.absorb_valid)
			begin
				st_nxt[7:0] = st_r[7:0] ^ ifc.absorb_byte;
				cnt_nxt = hrng_pkg::DRG_ROUNDS;
				mode_nxt = 1'b0;
			end
			else if (ifc.gen_req)
			begin
				st_nxt[31:0] = st_r[31:0] ^ hrng_pkg::DRG_GEN_TWEAK;
				cnt_nxt = hrng_pkg::DRG_ROUNDS;
				mode_nxt = 1'b1;
			end
		end
		else
		begin
			// Cryptographic state transition, every round
			st_nxt = st_rnd;
			cnt_nxt = cnt_r - 4'h1;
			if (cnt_r == 4'h1 && mode_r)
			begin
				// Output is a one-way mix, never a raw state word
				word_nxt = (st_rnd[31:0] ^ rotl(st_rnd[95:64], 11)) + st_rnd[63:32];
				st_nxt[127:96] = st_rnd[127:96] ^ word_nxt;
				done_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			st_r <= hrng_pkg::DRG_IV;
			cnt_r <= 4'h0;
			mode_r <= 1'b0;
			word_r <= 32'h0000_0000;
			done_r <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			mode_r <= mode_nxt;
			word_r <= word_nxt;
			done_r <= done_nxt;
		end
	end

	assign ifc.busy = (cnt_r != 4'h0);
	assign ifc.gen_word = word_r;
	assign ifc.gen_done = done_r;

	property p_gen_len;
		@(posedge clk) disable iff (!nrst)
		(ifc.gen_req && !ifc.absorb_valid && !ifc.busy) |=> ifc.busy[*8] ##1 ifc.gen_done;
	endproperty
	a_gen_len: assert property (p_gen_len) else $error("generate did not finish in 8 rounds");

endmodule // hrng_drg

// ### hdl/hrng_top.sv
`timescale 1ns/100ps
module hrng_top
(
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic NRST,
	// Raw entropy source
	input wire logic RAW_BIT,
	input wire logic RAW_VALID,
	// Random word stream
	output logic [hrng_pkg::WORD_W-1:0] WORD_DATA,
	output logic WORD_VALID,
	input wire logic WORD_READY,
	// Status
	output logic HEALTH_FAIL,
	output logic GEN_READY
);

	// Health test state
	logic last_bit_r, last_bit_nxt;
	logic [5:0] run_cnt_r, run_cnt_nxt;
	logic [8:0] apt_cnt_r, apt_cnt_nxt;
	logic [9:0] ones_r, ones_nxt, ones_sum, bias;
	logic [1:0] win_ok_r, win_ok_nxt;
	logic [2:0] ratio_r, ratio_nxt;
	logic fail_r, fail_nxt;
	logic bit_in;

	// Compressor and quarantine state
	logic fold_r, fold_nxt, fold_bit;
	logic [2:0] fold_cnt_r, fold_cnt_nxt;
	logic [7:0] byte_sh_r, byte_sh_nxt;
	logic [2:0] bit_cnt_r, bit_cnt_nxt;
	logic pend_valid_r, pend_valid_nxt;
	logic [7:0] pend_byte_r, pend_byte_nxt;
	logic [5:0] pend_age_r, pend_age_nxt;
	logic pend_go, release_byte;

	// Control state
	hrng_pkg::hrng_state_t state_r, state_nxt;
	logic [4:0] seed_cnt_r, seed_cnt_nxt;
	logic [7:0] credit_r, credit_nxt;
	logic [31:0] word_r, word_nxt;
	logic word_valid_r, word_valid_nxt;
	logic gen_pend_r, gen_pend_nxt;
	logic gen_start;

	hrng_drg_if drg_bus();

	hrng_drg hrng_drg_inst
	(
		.clk(REF_CLK),
		.nrst(NRST),
		.ifc(drg_bus.core)
	);

	// Health tests stop only once the source is declared failed
	assign bit_in = RAW_VALID && !fail_r;

	always_comb
	begin
		last_bit_nxt = last_bit_r;
		run_cnt_nxt = run_cnt_r;
		apt_cnt_nxt = apt_cnt_r;
		ones_nxt = ones_r;
		win_ok_nxt = win_ok_r;
		ratio_nxt = ratio_r;
		fail_nxt = fail_r;
		ones_sum = ones_r + {9'h000, RAW_BIT};
		bias = (ones_sum >= hrng_pkg::APT_MID) ? ones_sum - hrng_pkg::APT_MID
			: hrng_pkg::APT_MID - ones_sum;
		if (bit_in)
		begin
			last_bit_nxt = RAW_BIT;
			apt_cnt_nxt = apt_cnt_r + 9'h001;
			if (RAW_BIT == last_bit_r)
			begin
				run_cnt_nxt = run_cnt_r + 6'h01;
				if (run_cnt_r == hrng_pkg::RCT_LIMIT - 6'h01)
				begin
					fail_nxt = 1'b1;
				end
			end
			else
			begin
				run_cnt_nxt = hrng_pkg::RCT_RESET;
			end
			if (apt_cnt_r == hrng_pkg::APT_LAST)
			begin
				ones_nxt = 10'h000;
				if (ones_sum < hrng_pkg::APT_LO || ones_sum > hrng_pkg::APT_HI)
				begin
					fail_nxt = 1'b1;
				end
				else if (win_ok_r != hrng_pkg::STARTUP_WINDOWS)
				begin
					win_ok_nxt = win_ok_r + 2'h1;
				end
				// Biased window: fold more raw bits per internal bit
				ratio_nxt = (bias <= hrng_pkg::EST_TIGHT) ? hrng_pkg::RATIO_LO
					: hrng_pkg::RATIO_HI;
			end
			else
			begin
				ones_nxt = ones_sum;
			end
		end
	end

	always_ff @(posedge REF_CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			last_bit_r <= 1'b0;
			run_cnt_r <= hrng_pkg::RCT_RESET;
			apt_cnt_r <= 9'h000;
			ones_r <= 10'h000;
			win_ok_r <= 2'h0;
			ratio_r <= hrng_pkg::RATIO_HI;
			fail_r <= 1'b0;
		end
		else
		begin
			last_bit_r <= last_bit_nxt;
			run_cnt_r <= run_cnt_nxt;
			apt_cnt_r <= apt_cnt_nxt;
			ones_r <= ones_nxt;
			win_ok_r <= win_ok_nxt;
			ratio_r <= ratio_nxt;
			fail_r <= fail_nxt;
		end
	end

	// A byte ages in quarantine until a whole failure run would have shown
	assign pend_go = pend_valid_r && (pend_age_r == hrng_pkg::QUAR_BITS) && !fail_r;
	assign release_byte = pend_go && !drg_bus.busy
		&& ((state_r == hrng_pkg::ST_SEED && seed_cnt_r != hrng_pkg::SEED_BYTES)
		|| state_r == hrng_pkg::ST_RUN);
	assign fold_bit = fold_r ^ RAW_BIT;

	always_comb
	begin
		fold_nxt = fold_r;
		fold_cnt_nxt = fold_cnt_r;
		byte_sh_nxt = byte_sh_r;
		bit_cnt_nxt = bit_cnt_r;
		pend_valid_nxt = pend_valid_r;
		pend_byte_nxt = pend_byte_r;
		pend_age_nxt = pend_age_r;
		if (bit_in && pend_valid_r)
		begin
			// Compression pauses while the slot is full; tests still see every bit
			if (pend_age_r != hrng_pkg::QUAR_BITS)
			begin
				pend_age_nxt = pend_age_r + 6'h01;
			end
		end
		else if (bit_in)
		begin
			if (fold_cnt_r >= ratio_r - 3'h1)
			begin
				fold_nxt = 1'b0;
				fold_cnt_nxt = 3'h0;
				byte_sh_nxt = {byte_sh_r[6:0], fold_bit};
				bit_cnt_nxt = bit_cnt_r + 3'h1;
				if (bit_cnt_r == 3'h7)
				begin
					pend_valid_nxt = 1'b1;
					pend_byte_nxt = {byte_sh_r[6:0], fold_bit};
					pend_age_nxt = 6'h00;
				end
			end
			else
			begin
				fold_nxt = fold_bit;
				fold_cnt_nxt = fold_cnt_r + 3'h1;
			end
		end
		// Bytes that finish quarantine before the start-up test passed are discarded
		if (release_byte || (pend_go && state_r == hrng_pkg::ST_START))
		begin
			pend_valid_nxt = 1'b0;
		end
	end

	always_ff @(posedge REF_CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			fold_r <= 1'b0;
			fold_cnt_r <= 3'h0;
			byte_sh_r <= 8'h00;
			bit_cnt_r <= 3'h0;
			pend_valid_r <= 1'b0;
			pend_byte_r <= 8'h00;
			pend_age_r <= 6'h00;
		end
		else
		begin
			fold_r <= fold_nxt;
			fold_cnt_r <= fold_cnt_nxt;
			byte_sh_r <= byte_sh_nxt;
			bit_cnt_r <= bit_cnt_nxt;
			pend_valid_r <= pend_valid_nxt;
			pend_byte_r <= pend_byte_nxt;
			pend_age_r <= pend_age_nxt;
		end
	end

	// Only the compressed physical path feeds the generator
	assign drg_bus.absorb_valid = release_byte;
	assign drg_bus.absorb_byte = pend_byte_r;
	assign gen_start = (state_r == hrng_pkg::ST_RUN) && !fail_r && !release_byte
		&& !drg_bus.busy && !gen_pend_r && !word_valid_r
		&& (credit_r >= hrng_pkg::CREDIT_PER_WORD);
	assign drg_bus.gen_req = gen_start;

	always_comb
	begin
		state_nxt = state_r;
		seed_cnt_nxt = seed_cnt_r;
		credit_nxt = credit_r;
		word_nxt = word_r;
		word_valid_nxt = word_valid_r;
		gen_pend_nxt = gen_pend_r;
		case (state_r)
			hrng_pkg::ST_START:
			begin
				if (win_ok_r == hrng_pkg::STARTUP_WINDOWS)
				begin
					state_nxt = hrng_pkg::ST_SEED;
				end
			end
			hrng_pkg::ST_SEED:
			begin
				if (release_byte)
				begin
					seed_cnt_nxt = seed_cnt_r + 5'h01;
				end
				if (seed_cnt_r == hrng_pkg::SEED_BYTES && !drg_bus.busy)
				begin
					state_nxt = hrng_pkg::ST_RUN;
				end
			end
			hrng_pkg::ST_RUN:
			begin
				if (release_byte && credit_r <= hrng_pkg::CREDIT_MAX - hrng_pkg::CREDIT_PER_BYTE)
				begin
					credit_nxt = credit_r + hrng_pkg::CREDIT_PER_BYTE;
				end
				if (gen_start)
				begin
					credit_nxt = credit_r - hrng_pkg::CREDIT_PER_WORD;
					gen_pend_nxt = 1'b1;
				end
			end
			hrng_pkg::ST_FAIL:
			begin
				state_nxt = hrng_pkg::ST_FAIL;
			end
			default:
			begin
				state_nxt = hrng_pkg::ST_FAIL;
			end
		endcase
		if (drg_bus.gen_done && gen_pend_r)
		begin
			word_nxt = drg_bus.gen_word;
			word_valid_nxt = 1'b1;
			gen_pend_nxt = 1'b0;
		end
		if (WORD_VALID && WORD_READY)
		begin
			word_valid_nxt = 1'b0;
		end
		if (fail_r)
		begin
			state_nxt = hrng_pkg::ST_FAIL;
			word_valid_nxt = 1'b0;
			gen_pend_nxt = 1'b0;
		end
	end

	always_ff @(posedge REF_CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			state_r <= hrng_pkg::ST_START;
			seed_cnt_r <= 5'h00;
			credit_r <= 8'h00;
			word_r <= 32'h0000_0000;
			word_valid_r <= 1'b0;
			gen_pend_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			seed_cnt_r <= seed_cnt_nxt;
			credit_r <= credit_nxt;
			word_r <= word_nxt;
			word_valid_r <= word_valid_nxt;
			gen_pend_r <= gen_pend_nxt;
		end
	end

	assign WORD_DATA = word_r;
	assign WORD_VALID = word_valid_r && (state_r == hrng_pkg::ST_RUN) && !fail_r;
	assign HEALTH_FAIL = fail_r;
	assign GEN_READY = (state_r == hrng_pkg::ST_RUN);

	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!NRST);

	property p_valid_only_run;
		WORD_VALID |-> (state_r == hrng_pkg::ST_RUN) && (seed_cnt_r == hrng_pkg::SEED_BYTES);
	endproperty
	a_valid_only_run: assert property (p_valid_only_run) else $error("word valid before seeding");

	property p_start_blocked;
		(state_r == hrng_pkg::ST_START) |-> !WORD_VALID && !GEN_READY;
	endproperty
	a_start_blocked: assert property (p_start_blocked) else $error("output open during start-up");

	property p_fail_blocks;
		HEALTH_FAIL |-> !WORD_VALID ##1 !WORD_VALID;
	endproperty
	a_fail_blocks: assert property (p_fail_blocks) else $error("word valid after failure");

	property p_fail_sticky;
		HEALTH_FAIL |=> HEALTH_FAIL && (state_r == hrng_pkg::ST_FAIL);
	endproperty
	a_fail_sticky: assert property (p_fail_sticky) else $error("failure status cleared");

	property p_run_fail;
		(bit_in && RAW_BIT == last_bit_r && run_cnt_r == hrng_pkg::RCT_LIMIT - 6'h01)
			|=> HEALTH_FAIL;
	endproperty
	a_run_fail: assert property (p_run_fail) else $error("stuck run not flagged");

	property p_every_bit;
		bit_in |=> apt_cnt_r == $past(apt_cnt_r) + 9'h001;
	endproperty
	a_every_bit: assert property (p_every_bit) else $error("raw bit not counted");

	property p_credit;
		gen_start |-> credit_r >= hrng_pkg::CREDIT_PER_WORD
			##1 credit_r == $past(credit_r) - hrng_pkg::CREDIT_PER_WORD;
	endproperty
	a_credit: assert property (p_credit) else $error("word generated without credit");

	property p_quarantine;
		drg_bus.absorb_valid |-> pend_age_r == hrng_pkg::QUAR_BITS && !fail_r && pend_valid_r;
	endproperty
	a_quarantine: assert property (p_quarantine) else $error("byte used before aging");

	property p_ratio;
		(bit_in && apt_cnt_r == hrng_pkg::APT_LAST) |=> ratio_r ==
			(($past(bias) <= hrng_pkg::EST_TIGHT) ? hrng_pkg::RATIO_LO : hrng_pkg::RATIO_HI);
	endproperty
	a_ratio: assert property (p_ratio) else $error("fold ratio not set by estimator");

	property p_hold;
		(WORD_VALID && !WORD_READY) |=> $stable(WORD_DATA) && (WORD_VALID || HEALTH_FAIL);
	endproperty
	a_hold: assert property (p_hold) else $error("offered word changed");

	property p_cov_taken;
		WORD_VALID && WORD_READY;
	endproperty
	c_cov_taken: cover property (p_cov_taken);

	property p_cov_run;
		(state_r == hrng_pkg::ST_SEED) ##1 (state_r == hrng_pkg::ST_RUN);
	endproperty
	c_cov_run: cover property (p_cov_run);

	property p_cov_fail;
		WORD_VALID ##[1:1000] HEALTH_FAIL;
	endproperty
	c_cov_fail: cover property (p_cov_fail);

endmodule // hrng_top

// ### bench/hrng_consumer.sv
`timescale 1ns/100ps
module hrng_consumer
(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Word stream
	input wire logic [hrng_pkg::WORD_W-1:0] word_data,
	input wire logic word_valid,
	output logic word_ready,
	// Bench control and results
	input wire logic stall,
	output int taken_cnt,
	output logic [hrng_pkg::WORD_W-1:0] last_word
);
	initial
	begin
		word_ready = 1'b0;
		taken_cnt = 0;
		last_word = '0;
	end

	// Ready follows stall one edge late, so no race with the bench's stall update
	always @(posedge clk)
	begin
		word_ready <= ~stall;
	end

	// Word taken only on an edge where it is flagged valid
	always @(posedge clk)
	begin
		if (nrst && word_valid && word_ready)
		begin
			taken_cnt <= taken_cnt + 1;
			last_word <= word_data;
		end
	end
endmodule // hrng_consumer

// ### bench/tb_hybrid_rng_output_gating.sv
`timescale 1ns/100ps
module tb_hybrid_rng_output_gating;
	localparam int CYCLE_LIMIT = 60000;
	// Two start-up windows plus sixteen seed bytes at the tightest fold
	localparam int STARTUP_MIN = 1280;
	logic ref_clk;
	logic nrst;
	logic raw_bit;
	logic raw_valid;
	logic [hrng_pkg::WORD_W-1:0] word_data;
	logic word_valid;
	logic word_ready;
	logic health_fail;
	logic gen_ready;
	logic stall;
	int taken_cnt;
	logic [hrng_pkg::WORD_W-1:0] last_word;
	logic [15:0] lfsr;
	int error_cnt;
	int tests_run;
	int cycle_cnt;
	int bits_fed;

	hrng_top hrng_top_inst
	(
		.REF_CLK(ref_clk),
		.NRST(nrst),
		.RAW_BIT(raw_bit),
		.RAW_VALID(raw_valid),
		.WORD_DATA(word_data),
		.WORD_VALID(word_valid),
		.WORD_READY(word_ready),
		.HEALTH_FAIL(health_fail),
		.GEN_READY(gen_ready)
	);

	hrng_consumer hrng_consumer_inst
	(
		.clk(ref_clk),
		.nrst(nrst),
		.word_data(word_data),
		.word_valid(word_valid),
		.word_ready(word_ready),
		.stall(stall),
		.taken_cnt(taken_cnt),
		.last_word(last_word)
	);

	initial
	begin
		ref_clk = 1'b0;
		nrst = 1'b0;
		raw_bit = 1'b0;
		raw_valid = 1'b0;
		stall = 1'b0;
		lfsr = 16'hace1;
		error_cnt = 0;
		tests_run = 0;
		cycle_cnt = 0;
		bits_fed = 0;
	end

	always #2.5 ref_clk = ~ref_clk;

	always @(posedge ref_clk)
	begin
		if (nrst && raw_valid)
			bits_fed++;
		cycle_cnt++;
		if (cycle_cnt == CYCLE_LIMIT)
		begin
			error_cnt++;
			$display("wrong value at %0t: run did not finish", $time);
			give_verdict();
		end
	end

	task automatic give_verdict();
		if (error_cnt == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic check(input logic ok, input string msg);
		tests_run++;
		if (ok !== 1'b1)
		begin
			error_cnt++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask

	// Modes: 0 balanced sequence, 1 ones, 2 zeros, 3 one in four
	task automatic feed(input int n, input int mode);
		for (int i = 0; i < n; i++)
		begin
			@(posedge ref_clk);
			#1;
			lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
			case (mode)
				0: raw_bit = lfsr[15];
				1: raw_bit = 1'b1;
				2: raw_bit = 1'b0;
				default: raw_bit = (i % 4 == 3);
			endcase
			raw_valid = 1'b1;
		end
		@(posedge ref_clk);
		#1;
		raw_valid = 1'b0;
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic do_reset();
		#1;
		nrst = 1'b0;
		stall = 1'b0;
		repeat (8) @(posedge ref_clk);
		#1;
		check(!word_valid && !health_fail && !gen_ready, "outputs active in reset");
		nrst = 1'b1;
	endtask

	task automatic run_startup();
		int start;
		int n;
		start = bits_fed;
		n = 0;
		while (gen_ready !== 1'b1 && n < 8000)
		begin
			check(word_valid === 1'b0, "word offered before seeding");
			feed(1, 0);
			n++;
		end
		check(gen_ready === 1'b1, "generator never ready");
		check(bits_fed - start >= STARTUP_MIN, "ready before start-up test");
	endtask

	task automatic run_hold();
		logic [hrng_pkg::WORD_W-1:0] held;
		int n;
		int t0;
		stall = 1'b1;
		n = 0;
		while (word_valid !== 1'b1 && n < 4000)
		begin
			feed(1, 0);
			n++;
		end
		held = word_data;
		check(word_valid === 1'b1, "no word offered");
		for (int i = 0; i < 40; i++)
		begin
			feed(1, 0);
			check(word_valid === 1'b1 && word_data === held, "word moved untaken");
		end
		t0 = taken_cnt;
		stall = 1'b0;
		step(3);
		check(taken_cnt == t0 + 1 && last_word === held, "held word not taken");
		n = 0;
		while (taken_cnt == t0 + 1 && n < 800)
		begin
			feed(1, 0);
			n++;
		end
		check(last_word !== held, "generator repeated a word");
	endtask

	task automatic run_rate();
		int t0;
		int f0;
		stall = 1'b0;
		t0 = taken_cnt;
		f0 = bits_fed;
		feed(1500, 0);
		check(taken_cnt > t0, "no words while fed");
		check((taken_cnt - t0) * 32 <= bits_fed - f0 + int'(hrng_pkg::CREDIT_MAX),
			"output outran input");
		t0 = taken_cnt;
		step(300);
		// Banked credit allows at most the cap plus a word in flight
		check(taken_cnt - t0 <= 5, "too many words unfed");
		t0 = taken_cnt;
		step(300);
		check(taken_cnt == t0 && word_valid === 1'b0, "word without input");
	endtask

	task automatic run_fail_in_run();
		int t0;
		stall = 1'b1;
		feed(600, 0);
		check(word_valid === 1'b1, "no word waiting");
		feed(1, 2);
		feed(39, 1);
		step(2);
		check(health_fail === 1'b0 && word_valid === 1'b1, "early failure");
		feed(1, 1);
		step(1);
		check(health_fail === 1'b1, "run of forty not flagged");
		check(word_valid === 1'b0, "word still offered after fault");
		t0 = taken_cnt;
		stall = 1'b0;
		feed(600, 0);
		check(taken_cnt == t0 && word_valid === 1'b0, "word after failure");
		check(health_fail === 1'b1, "failure not sticky");
	endtask

	task automatic run_window_fail();
		feed(511, 3);
		step(2);
		check(health_fail === 1'b0, "window judged early");
		feed(1, 3);
		step(1);
		check(health_fail === 1'b1, "biased window passed");
		check(gen_ready === 1'b0 && word_valid === 1'b0, "output after bias");
	endtask

	initial
	begin
		do_reset();
		run_startup();
		run_hold();
		run_rate();
		run_fail_in_run();
		do_reset();
		run_window_fail();
		do_reset();
		run_startup();
		give_verdict();
	end
endmodule // tb_hybrid_rng_output_gating
